// ---- core/btr_recorder.sv ----
// Bus cycle trace recorder: capture, timestamp, trace memory and register port.
`timescale 1ns/100ps
`default_nettype none
`include "btr_regs.svh"
module btr_recorder
   import btr_pkg::*;
#(
   parameter int DEPTH_LOG2 = 8,
   parameter bit FAST_PROBE = 1'b0
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire logic CYC_END_I,
   input wire btr_cycle_t CYC_I,
   input wire logic VIOL_I,
   input wire logic BRK_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [31:0] REG_RDATA_O,
   output logic EVT_VALID_O,
   output btr_rec_t EVT_REC_O,
   output logic RUN_O
);
   localparam int DEPTH = 1 << DEPTH_LOG2;
   // Divider counts from the system rate to each timestamp rate.
   localparam int DIV_SLOW = (`BTR_CLK_MHZ * 10) / `BTR_SLOW_MHZ_X10;
   localparam int DIV_MID = (`BTR_CLK_MHZ * 10) / `BTR_MID_MHZ_X10;
   localparam int DIV_FAST = (`BTR_CLK_MHZ * 10) / `BTR_FAST_MHZ_X10;

   btr_state_t state_ff;
   btr_mode_t mode_ff;
   logic [1:0] rate_ff;
   logic [23:0] tstamp_ff;
   logic [15:0] div_ff;
   logic [15:0] div_lim;
   logic viol_ff;
   logic brk_ff;
   logic [DEPTH_LOG2-1:0] wptr_ff;
   logic [DEPTH_LOG2:0] count_ff;
   logic [DEPTH_LOG2-1:0] line_ff;
   logic [DEPTH_LOG2-1:0] rd_idx;
   logic [31:0] rdata_ff;
   logic ev_valid_ff;
   btr_rec_t ev_rec_ff;
   btr_rec_t nxt_rec;
   btr_rec_t mem [DEPTH];
   btr_rec_t rd_rec;
   logic run_req;
   logic erase_req;
   logic ctrl_wr;
   logic capture;

   assign ctrl_wr = CE_I && REG_WR_I && (REG_ADDR_I == `BTR_ADDR_CTRL);
   assign run_req = REG_WDATA_I[`BTR_CTRL_RUN_BIT];
   assign erase_req = ctrl_wr && REG_WDATA_I[`BTR_CTRL_ERASE_BIT];
   assign capture = CE_I && (state_ff == BTR_RUN) && CYC_END_I;

   // Run/erase sequencing; erase walks every line so nothing stale remains.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         state_ff <= BTR_IDLE;
      end else if (CE_I) begin
         unique case (state_ff)
            BTR_IDLE: begin
               if (erase_req) begin
                  state_ff <= BTR_ERASE;
               end else if (ctrl_wr && run_req) begin
                  state_ff <= BTR_RUN;
               end
            end
            BTR_RUN: begin
               if (erase_req) begin
                  state_ff <= BTR_ERASE;
               end else if (ctrl_wr && !run_req) begin
                  state_ff <= BTR_IDLE;
               end
            end
            BTR_ERASE: begin
               if (wptr_ff == DEPTH_LOG2'(DEPTH - 1)) begin
                  state_ff <= BTR_IDLE;
               end
            end
            default: state_ff <= BTR_IDLE;
         endcase
      end
   end

   // Mode and rate; mode writes are ignored while running so the format is fixed.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         mode_ff <= btr_mode_t'(`BTR_MODE_RESET);
         rate_ff <= `BTR_RATE_RESET;
      end else if (ctrl_wr) begin
         if (state_ff != BTR_RUN) begin
            mode_ff <= btr_mode_t'(REG_WDATA_I[`BTR_CTRL_MODE_LSB +: 2]);
         end
         if (REG_WDATA_I[`BTR_CTRL_RATE_LSB +: 2] != 2'h0) begin
            rate_ff <= REG_WDATA_I[`BTR_CTRL_RATE_LSB +: 2];
         end
      end
   end

   // Rate code to divider length; code 0 is refused above.
   always_comb begin
      unique case (rate_ff)
         `BTR_RATE_SLOW: div_lim = 16'(DIV_SLOW - 1);
         `BTR_RATE_MID: div_lim = 16'(DIV_MID - 1);
         default: div_lim = 16'(DIV_FAST - 1);
      endcase
   end

   // Timestamp prescaler and 24-bit counter, zeroed on entry to emulation.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         div_ff <= 16'h0000;
         tstamp_ff <= 24'h000000;
      end else if (CE_I) begin
         if (ctrl_wr && run_req && state_ff == BTR_IDLE) begin
            div_ff <= 16'h0000;
            tstamp_ff <= 24'h000000;
         end else if (div_ff >= div_lim) begin
            div_ff <= 16'h0000;
            tstamp_ff <= tstamp_ff + 24'h000001;
         end else begin
            div_ff <= div_ff + 16'h0001;
         end
      end
   end

   // Sticky markers; cleared only on entry to emulation, an event then still wins.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         viol_ff <= 1'b0;
         brk_ff <= 1'b0;
      end else if (CE_I) begin
         if (VIOL_I) begin
            viol_ff <= 1'b1;
         end else if (ctrl_wr && run_req && state_ff == BTR_IDLE) begin
            viol_ff <= 1'b0;
         end
         if (BRK_I) begin
            brk_ff <= 1'b1;
         end else if (ctrl_wr && run_req && state_ff == BTR_IDLE) begin
            brk_ff <= 1'b0;
         end
      end
   end

   // Build the record with the field set of the current mode.
   always_comb begin
      nxt_rec = '0;
      nxt_rec.addr = CYC_I.addr;
      nxt_rec.data = CYC_I.data;
      nxt_rec.wr = CYC_I.wr;
      nxt_rec.emu_hit = CYC_I.emu_hit;
      nxt_rec.fcode = CYC_I.fcode;
      nxt_rec.viol = viol_ff;
      nxt_rec.post_brk = brk_ff;
      nxt_rec.bus_error_input = CYC_I.bus_error_input;
      nxt_rec.tstamp = tstamp_ff;
      // Ack, width and operand start kept in every mode for the full listing.
      nxt_rec.port_ack = CYC_I.port_ack;
      nxt_rec.width_code = CYC_I.width_code;
      nxt_rec.ocs = CYC_I.ocs;
      unique case (mode_ff)
         BTR_MODE0: begin
            nxt_rec.addr = {8'h00, CYC_I.addr[23:0]};
            nxt_rec.data = {16'h0000, CYC_I.data[15:0]};
            nxt_rec.ipl = CYC_I.ipl;
            nxt_rec.autovector_input = CYC_I.autovector_input;
            nxt_rec.pending_irq_signal = CYC_I.pending_irq_signal;
            nxt_rec.probe = CYC_I.probe;
         end
         BTR_MODE1: begin
            nxt_rec.addr = {8'h00, CYC_I.addr[23:0]};
            nxt_rec.ipl = CYC_I.ipl;
            nxt_rec.autovector_input = CYC_I.autovector_input;
            nxt_rec.pending_irq_signal = CYC_I.pending_irq_signal;
         end
         BTR_MODE2: begin
            nxt_rec.ipl = 3'h0;
         end
         BTR_MODE3: begin
            nxt_rec.data = {16'h0000, CYC_I.data[15:0]};
            nxt_rec.locked = CYC_I.locked;
            nxt_rec.cache_off = CYC_I.cache_off;
            nxt_rec.ipl = CYC_I.ipl;
            nxt_rec.autovector_input = CYC_I.autovector_input;
            nxt_rec.pending_irq_signal = CYC_I.pending_irq_signal;
            if (!FAST_PROBE) begin
               nxt_rec.probe = {10'h000, CYC_I.probe[5:0]};
            end
         end
      endcase
   end

   // Trace memory: circular write, or a sweep of zeros while erasing.
   always_ff @(posedge SYS_CLK_I) begin
      if (CE_I) begin
         if (state_ff == BTR_ERASE) begin
            mem[wptr_ff] <= '0;
         end else if (capture) begin
            mem[wptr_ff] <= nxt_rec;
         end
      end
   end

   // Write pointer and fill count.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         wptr_ff <= '0;
         count_ff <= '0;
      end else if (CE_I) begin
         if (erase_req) begin
            wptr_ff <= '0;
            count_ff <= '0;
         end else if (state_ff == BTR_ERASE) begin
            wptr_ff <= (wptr_ff == DEPTH_LOG2'(DEPTH - 1)) ? '0 : wptr_ff + 1'b1;
         end else if (capture) begin
            wptr_ff <= wptr_ff + 1'b1;
            if (count_ff != (DEPTH_LOG2+1)'(DEPTH)) begin
               count_ff <= count_ff + 1'b1;
            end
         end
      end
   end

   // Line zero is the newest record; older lines lie further back.
   assign rd_idx = wptr_ff - DEPTH_LOG2'(1) - line_ff;
   assign rd_rec = mem[rd_idx];

   // Line select register.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         line_ff <= '0;
      end else if (CE_I && REG_WR_I && REG_ADDR_I == `BTR_ADDR_LINE) begin
         line_ff <= REG_WDATA_I[DEPTH_LOG2-1:0];
      end
   end

   // Read port: data stands one cycle after the strobe, zero when unmapped.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         rdata_ff <= `BTR_ZERO32;
      end else if (CE_I) begin
         rdata_ff <= `BTR_ZERO32;
         if (REG_RD_I) begin
            case (REG_ADDR_I)
               `BTR_ADDR_CTRL: rdata_ff <= {23'h0, state_ff == BTR_RUN, 2'h0, rate_ff,
                                            2'h0, mode_ff};
               `BTR_ADDR_STATUS: rdata_ff <= {27'h0, viol_ff, brk_ff, state_ff};
               `BTR_ADDR_TSTAMP: rdata_ff <= {8'h00, tstamp_ff};
               `BTR_ADDR_CAPCNT: rdata_ff <= 32'(count_ff);
               `BTR_ADDR_LINE: rdata_ff <= 32'(line_ff);
               `BTR_ADDR_REC_ADDR: rdata_ff <= rd_rec.addr;
               `BTR_ADDR_REC_DATA: rdata_ff <= rd_rec.data;
               // Probe bits on top, one bit per flag below, bit zero spare.
               `BTR_ADDR_REC_STAT: rdata_ff <= {rd_rec.probe, rd_rec.wr, rd_rec.emu_hit,
                  rd_rec.locked, rd_rec.fcode, rd_rec.viol, rd_rec.post_brk,
                  rd_rec.bus_error_input, rd_rec.ipl, rd_rec.cache_off, rd_rec.autovector_input,
                  rd_rec.pending_irq_signal, 1'b0};
               // Ack, width and operand start ride with the time word: the status word
               // has no room left, and this way they come back beside the full timestamp.
               `BTR_ADDR_REC_TIME: rdata_ff <= {3'h0, rd_rec.port_ack, rd_rec.width_code,
                  rd_rec.ocs, rd_rec.tstamp};
               default: rdata_ff <= `BTR_ZERO32;
            endcase
         end
      end
   end

   // Event monitor copy of each stored record.
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         ev_valid_ff <= 1'b0;
         ev_rec_ff <= '0;
      end else if (CE_I) begin
         ev_valid_ff <= capture;
         if (capture) begin
            ev_rec_ff <= nxt_rec;
         end
      end
   end

   assign REG_RDATA_O = rdata_ff;
   assign EVT_VALID_O = ev_valid_ff;
   assign EVT_REC_O = ev_rec_ff;
   assign RUN_O = (state_ff == BTR_RUN);

   // Checks beside the logic.
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   mode_reset_a: assert property ($rose(!RST_I) |-> mode_ff == BTR_MODE2)
      else $error("mode not two after reset");
   rate_reset_a: assert property ($rose(!RST_I) |-> rate_ff == `BTR_RATE_FAST)
      else $error("rate not fast after reset");
   // The wrap itself lies millions of cycles out, so every single step is checked too.
   ts_wrap_a: assert property (CE_I && tstamp_ff == `BTR_TS_MAX && div_ff >= div_lim
      && !(ctrl_wr && run_req && state_ff == BTR_IDLE) |=> tstamp_ff == 24'h000000)
      else $error("timestamp did not wrap");
   ts_step_a: assert property (CE_I && div_ff >= div_lim
      && !(ctrl_wr && run_req && state_ff == BTR_IDLE)
      |=> tstamp_ff == $past(tstamp_ff) + 24'h000001)
      else $error("timestamp did not step");
   ts_entry_a: assert property (ctrl_wr && run_req && state_ff == BTR_IDLE
      |=> tstamp_ff == 24'h000000)
      else $error("timestamp not zeroed on entry");
   // A read right after a capture must already see the new line, with no bypass.
   newest_line_a: assert property (capture && !erase_req
      ##1 (REG_RD_I && REG_ADDR_I == `BTR_ADDR_REC_ADDR && CE_I && line_ff == '0)
      |=> REG_RDATA_O == $past(nxt_rec.addr, 2))
      else $error("line zero is not the newest cycle");
   evt_copy_a: assert property (capture |=> EVT_VALID_O && EVT_REC_O == $past(nxt_rec))
      else $error("event monitor missed a record");
   viol_mark_a: assert property (CE_I && VIOL_I |=> viol_ff)
      else $error("violation marker not set");
   // Markers stay up until the next entry to emulation, however long the run lasts.
   viol_hold_a: assert property (viol_ff && !(ctrl_wr && run_req && state_ff == BTR_IDLE)
      |=> viol_ff)
      else $error("violation marker dropped");
   brk_mark_a: assert property (CE_I && BRK_I |=> brk_ff)
      else $error("breakpoint marker not set");
   brk_hold_a: assert property (brk_ff && !(ctrl_wr && run_req && state_ff == BTR_IDLE)
      |=> brk_ff)
      else $error("breakpoint marker dropped");
   locked_mode_a: assert property (mode_ff != BTR_MODE3
      |-> !nxt_rec.locked && !nxt_rec.cache_off)
      else $error("mode three flag outside mode three");
   // Refused writes must leave the setting exactly as it was.
   rate_keep_a: assert property (ctrl_wr
      && REG_WDATA_I[`BTR_CTRL_RATE_LSB +: 2] == 2'h0 |=> rate_ff == $past(rate_ff))
      else $error("rate code zero was taken");
   mode_keep_a: assert property (ctrl_wr && state_ff == BTR_RUN
      |=> mode_ff == $past(mode_ff))
      else $error("mode changed while running");
   erase_len_a: assert property ($rose(state_ff == BTR_ERASE) && CE_I
      |-> count_ff == '0)
      else $error("erase did not clear count");

   run_cov: cover property (state_ff == BTR_IDLE ##1 state_ff == BTR_RUN);
   wrap_cov: cover property (capture && count_ff == (DEPTH_LOG2+1)'(DEPTH));
   erase_cov: cover property (state_ff == BTR_ERASE ##1 state_ff == BTR_IDLE);
   mode3_cov: cover property (capture && mode_ff == BTR_MODE3);
endmodule : btr_recorder
`default_nettype wire

// ---- core/btr_regs.svh ----
// Register offsets, field positions, reset values and timing figures of the trace recorder.
`ifndef BTR_REGS_SVH
`define BTR_REGS_SVH
`define BTR_ADDR_CTRL 8'h00
`define BTR_ADDR_STATUS 8'h04
`define BTR_ADDR_TSTAMP 8'h08
`define BTR_ADDR_CAPCNT 8'h0C
`define BTR_ADDR_LINE 8'h10
`define BTR_ADDR_REC_ADDR 8'h14
`define BTR_ADDR_REC_DATA 8'h18
`define BTR_ADDR_REC_STAT 8'h1C
`define BTR_ADDR_REC_TIME 8'h20
`define BTR_CTRL_MODE_LSB 0
`define BTR_CTRL_RATE_LSB 4
`define BTR_CTRL_RUN_BIT 8
`define BTR_CTRL_ERASE_BIT 9
`define BTR_MODE_RESET 2'h2
`define BTR_RATE_RESET 2'h3
`define BTR_RATE_SLOW 2'h1
`define BTR_RATE_MID 2'h2
`define BTR_RATE_FAST 2'h3
`define BTR_CLK_MHZ 100
`define BTR_SLOW_MHZ_X10 1
`define BTR_MID_MHZ_X10 10
`define BTR_FAST_MHZ_X10 100
`define BTR_TS_MAX 24'hFFFFFF
`define BTR_ZERO32 32'h0000_0000
`endif

// ---- core/btr_pkg.sv ----
// Types shared by the trace recorder: bus-cycle sample and stored record.
`default_nettype none
package btr_pkg;
   // One observed bus cycle, presented at its termination.
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic wr;
      logic emu_hit;
      logic locked;
      logic [2:0] fcode;
      logic bus_error_input;
      logic [2:0] ipl;
      logic cache_off;
      logic autovector_input;
      logic pending_irq_signal;
      logic [1:0] port_ack;
      logic [1:0] width_code;
      logic ocs;
      logic [15:0] probe;
   } btr_cycle_t;
   // Stored record, fields masked by the trace mode.
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic wr;
      logic emu_hit;
      logic locked;
      logic [2:0] fcode;
      logic viol;
      logic post_brk;
      logic bus_error_input;
      logic [2:0] ipl;
      logic cache_off;
      logic autovector_input;
      logic pending_irq_signal;
      logic [1:0] port_ack;
      logic [1:0] width_code;
      logic ocs;
      logic [15:0] probe;
      logic [23:0] tstamp;
   } btr_rec_t;
   typedef enum logic [1:0] {
      BTR_MODE0 = 2'h0,
      BTR_MODE1 = 2'h1,
      BTR_MODE2 = 2'h2,
      BTR_MODE3 = 2'h3
   } btr_mode_t;
   typedef enum logic [2:0] {
      BTR_IDLE = 3'b001,
      BTR_RUN = 3'b010,
      BTR_ERASE = 3'b100
   } btr_state_t;
endpackage : btr_pkg
`default_nettype wire

// ---- testbench/btr_bus_model.sv ----
// Behavioural target bus: terminates one bus cycle per request after some wait states.
`timescale 1ns/100ps
`default_nettype none
module btr_bus_model
   import btr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire btr_cycle_t cyc_i,
   input wire logic [3:0] lat_i,
   output logic end_o,
   output btr_cycle_t cyc_o
);
   logic busy_ff;
   logic [3:0] cnt_ff;
   btr_cycle_t hold_ff;
   // Count out the wait states, then terminate for exactly one clock.
   always_ff @(posedge clk_i) begin
      end_o <= 1'b0;
      if (rst_i) begin
         busy_ff <= 1'b0;
         hold_ff <= '0;
      end else if (go_i) begin
         busy_ff <= 1'b1;
         cnt_ff <= lat_i;
         hold_ff <= cyc_i;
      end else if (busy_ff && cnt_ff == 4'h0) begin
         busy_ff <= 1'b0;
         end_o <= 1'b1;
      end else if (busy_ff) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end
   // Lines are only valid at termination, so show the inverse elsewhere.
   assign cyc_o = end_o ? hold_ff : ~hold_ff;
endmodule // btr_bus_model
`default_nettype wire

// ---- testbench/btr_recorder_tb_top.sv ----
// Self-checking testbench of the bus cycle trace recorder.
`timescale 1ns/100ps
`default_nettype none
`include "btr_regs.svh"
module btr_recorder_tb_top
   import btr_pkg::*;
;
   logic clk, rst, ce, go, viol, brk, reg_wr, reg_rd, end_o, evt_valid, run_o;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, rdata, d, t0;
   logic [3:0] lat;
   btr_cycle_t cyc, cyc_bus;
   btr_rec_t evt_rec;
   btr_rec_t hist[$];
   logic vf, bf;
   int errors = 0;
   int total_checks = 0;
   int j, per;
   time t_run;

   btr_recorder #(.DEPTH_LOG2(4), .FAST_PROBE(1'b0)) btr_recorder_i (
      .SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce), .CYC_END_I(end_o), .CYC_I(cyc_bus),
      .VIOL_I(viol), .BRK_I(brk), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
      .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(rdata), .EVT_VALID_O(evt_valid),
      .EVT_REC_O(evt_rec), .RUN_O(run_o));
   btr_bus_model btr_bus_model_i (.clk_i(clk), .rst_i(rst), .go_i(go), .cyc_i(cyc),
      .lat_i(lat), .end_o(end_o), .cyc_o(cyc_bus));

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Expected stored record: fields the mode lacks read as zero.
   function automatic btr_rec_t exp_rec(btr_cycle_t c, logic [1:0] m, logic v, logic b);
      btr_rec_t r;
      r = '0;
      r.addr = m[1] ? c.addr : {8'h00, c.addr[23:0]};
      r.data = (m == 2'h1 || m == 2'h2) ? c.data : {16'h0000, c.data[15:0]};
      r.wr = c.wr;
      r.emu_hit = c.emu_hit;
      r.fcode = c.fcode;
      r.viol = v;
      r.post_brk = b;
      r.bus_error_input = c.bus_error_input;
      r.locked = (m == 2'h3) ? c.locked : 1'b0;
      r.cache_off = (m == 2'h3) ? c.cache_off : 1'b0;
      r.ipl = (m != 2'h2) ? c.ipl : 3'h0;
      r.autovector_input = (m != 2'h2) && c.autovector_input;
      r.pending_irq_signal = (m != 2'h2) && c.pending_irq_signal;
      r.port_ack = c.port_ack;
      r.width_code = c.width_code;
      r.ocs = c.ocs;
      r.probe = (m == 2'h0) ? c.probe : (m == 2'h3) ? {10'h000, c.probe[5:0]} : 16'h0000;
      return r;
   endfunction

   // Status word of a stored line as the register map packs it.
   function automatic logic [31:0] stat_word(btr_rec_t r);
      return {r.probe, r.wr, r.emu_hit, r.locked, r.fcode, r.viol, r.post_brk, r.bus_error_input,
         r.ipl, r.cache_off, r.autovector_input, r.pending_irq_signal, 1'b0};
   endfunction

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: register got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rec(input btr_rec_t got, input btr_rec_t exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: record got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample mid-cycle.
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask

   // One random bus cycle; optional violation or breakpoint pulse beside it.
   task automatic bus_cycle(input logic [1:0] m, input logic v, input logic b);
      logic [127:0] rnd;
      btr_cycle_t c;
      btr_rec_t got;
      rnd = {$urandom, $urandom, $urandom, $urandom};
      c = rnd[97:0];
      @(posedge clk);
      go <= 1'b1;
      cyc <= c;
      lat <= 4'($urandom_range(0, 5));
      viol <= v;
      brk <= b;
      @(posedge clk);
      go <= 1'b0;
      viol <= 1'b0;
      brk <= 1'b0;
      vf = vf | v;
      bf = bf | b;
      for (int i = 0; i < 30 && end_o !== 1'b1; i++) @(negedge clk);
      // Ask for line zero on the capture edge, so the read lands right after it.
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= `BTR_ADDR_REC_ADDR;
      @(negedge clk);
      chk32({31'h0, evt_valid}, 32'h1);
      got = evt_rec;
      chk32({8'h00, got.tstamp}, 32'((($time - 5 - t_run) / 10 - 1) / 10));
      got.tstamp = 24'h000000;
      hist.push_front(exp_rec(c, m, vf, bf));
      chk_rec(got, hist[0]);
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk32(rdata, hist[0].addr);
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // A hang counts as a mismatch; the whole run needs well under this span.
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      final_report();
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      {go, viol, brk, reg_wr, reg_rd, vf, bf} = '0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      cyc = '0;
      lat = 4'h0;
      void'($urandom(28147));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd_reg(`BTR_ADDR_CTRL, d);
      chk32(d, 32'h0000_0032);
      rd_reg(`BTR_ADDR_STATUS, d);
      chk32(d, 32'h0000_0001);
      rd_reg(8'h40, d);
      chk32(d, 32'h0);
      wr_reg(`BTR_ADDR_STATUS, 32'hFFFF_FFFF);
      rd_reg(`BTR_ADDR_STATUS, d);
      chk32(d, 32'h0000_0001);
      $display("test reset and map done");
      // Each rate code, checked by readback and by ticks over about 1000 clocks.
      for (int r = 1; r < 4; r++) begin
         wr_reg(`BTR_ADDR_CTRL, 32'(r << 4) | 32'h2);
         rd_reg(`BTR_ADDR_CTRL, d);
         chk32(d, 32'(r << 4) | 32'h2);
         per = (r == 1) ? 1000 : (r == 2) ? 100 : 10;
         rd_reg(`BTR_ADDR_TSTAMP, t0);
         repeat (1000) @(posedge clk);
         rd_reg(`BTR_ADDR_TSTAMP, d);
         d = d - t0;
         chk32({31'h0, d + 1 >= 1002 / per && d <= 1002 / per + 1}, 32'h1);
      end
      wr_reg(`BTR_ADDR_CTRL, 32'h2);
      rd_reg(`BTR_ADDR_CTRL, d);
      chk32(d, 32'h0000_0032);
      // Clock enable low must freeze the timestamp as well.
      rd_reg(`BTR_ADDR_TSTAMP, t0);
      @(posedge clk);
      ce <= 1'b0;
      repeat (100) @(posedge clk);
      ce <= 1'b1;
      rd_reg(`BTR_ADDR_TSTAMP, d);
      chk32({31'h0, d - t0 <= 32'h1}, 32'h1);
      $display("test rates done");
      for (int m = 0; m < 4; m++) begin
         wr_reg(`BTR_ADDR_CTRL, 32'h30 | m);
         wr_reg(`BTR_ADDR_CTRL, 32'h230 | m);
         for (int i = 0; i < 40; i++) begin
            rd_reg(`BTR_ADDR_STATUS, d);
            if (d[0] === 1'b1) break;
         end
         rd_reg(`BTR_ADDR_CAPCNT, d);
         chk32(d, 32'h0);
         rd_reg(`BTR_ADDR_REC_ADDR, d);
         chk32(d, 32'h0);
         wr_reg(`BTR_ADDR_CTRL, 32'h130 | m);
         t_run = $time;
         rd_reg(`BTR_ADDR_TSTAMP, d);
         chk32({31'h0, d < 2}, 32'h1);
         chk32({31'h0, run_o}, 32'h1);
         wr_reg(`BTR_ADDR_CTRL, 32'h130 | (m ^ 1));
         rd_reg(`BTR_ADDR_CTRL, d);
         chk32(d & 32'h103, 32'h100 | m);
         wr_reg(`BTR_ADDR_LINE, 32'h0);
         vf = 1'b0;
         bf = 1'b0;
         hist.delete();
         for (int i = 0; i < 18; i++) begin
            bus_cycle(2'(m), i == 8 && m[0], i == 12 && m[1]);
         end
         wr_reg(`BTR_ADDR_CTRL, 32'h30 | m);
         rd_reg(`BTR_ADDR_CAPCNT, d);
         chk32(d, 32'd16);
         chk32({31'h0, run_o}, 32'h0);
         // Newest, next and oldest surviving lines.
         for (int k = 0; k < 3; k++) begin
            j = (k == 2) ? 15 : k;
            wr_reg(`BTR_ADDR_LINE, 32'(j));
            rd_reg(`BTR_ADDR_REC_ADDR, d);
            chk32(d, hist[j].addr);
            rd_reg(`BTR_ADDR_REC_DATA, d);
            chk32(d, hist[j].data);
            rd_reg(`BTR_ADDR_REC_STAT, d);
            chk32(d, stat_word(hist[j]));
            rd_reg(`BTR_ADDR_REC_TIME, d);
            chk32(d[31:24], {3'h0, hist[j].port_ack, hist[j].width_code, hist[j].ocs});
         end
         $display("test mode %0d done", m);
      end
      final_report();
   end
endmodule // btr_recorder_tb_top
`default_nettype wire
